// [ouvfs_defines.vh]
/*
 Constants for the output undervoltage fault supervisor.
 Assumes a 25 MHz device clock and linear-16 unsigned voltage codes (LSB = 2^-13 V).
*/
// Behaviour
// - Thresholds are 16-bit unsigned codes, volts equal code times two to minus thirteen.
// - A threshold write above 5.5 V is refused; previous value kept.
// - Undervoltage detection is masked while ramping, before output good, or disabled.
// - Undervoltage fault sets summary bit, undervoltage fault bit, and alerts host.
// - Reset loads warning with 0.88 and fault with 0.85 of the strapped setpoint.
// - Response byte resets to 80h; only bits 7:6 = 10 enable disable-and-retry.
// - Fault drives alert line low and sets a fault bit cleared only by clear-faults.
// - Retry setting 000 keeps output disabled until faults are cleared.
// - Retry setting nonzero restarts forever until commanded off, bias lost, or other fault.
// - Restart spacing is (delay field plus one) times 35 ms.
// - Retry delay is timed from fault detection to restart attempt.
// - After retry delay the turn-on delay still applies before ramping.
// - Output above overvoltage warning sets summary bit, warning bit, and alerts host.
`ifndef OUVFS_DEFINES_VH
`define OUVFS_DEFINES_VH

`define OUVFS_CMD_OV_WARN 8'h42
`define OUVFS_CMD_UV_WARN 8'h43
`define OUVFS_CMD_UV_FAULT 8'h44
`define OUVFS_CMD_UV_RESP 8'h45
`define OUVFS_CMD_CLEAR 8'h03

`define OUVFS_RESP_RESET 8'h80
`define OUVFS_RESP_RETRY_MODE 2'b10
`define OUVFS_RESP_MODE 7:6
`define OUVFS_RESP_RETRY 5:3
`define OUVFS_RESP_DELAY 2:0
`define OUVFS_MAX_CODE 16'hb000
`define OUVFS_WARN_NUM 17'h00058
`define OUVFS_FAULT_NUM 17'h00055
`define OUVFS_PCT_DIV 17'h00064
`define OUVFS_OV_WARN_NUM 17'h0006c

`define OUVFS_CLK_HZ 25000000
`define OUVFS_MS_CYCLES (`OUVFS_CLK_HZ / 1000)
`define OUVFS_RETRY_UNIT_MS 35

`define OUVFS_SW_VOUT_BIT 15
`define OUVFS_SV_OV_WARN_BIT 6
`define OUVFS_SV_UV_FAULT_BIT 4

`endif

// [ouvfs_ms_tick.v]
/*
 Millisecond tick divider.
 Assumes a free-running device clock; tick is one cycle wide.
*/
`timescale 1ns/100ps
`include "ouvfs_defines.vh"
module ouvfs_ms_tick (
   input wire clock, // Device clock
   input wire rstn, // Async reset, active low
   input wire restart, // Restart the count
   output reg tick // One-cycle millisecond pulse
);
   localparam integer LAST_I = `OUVFS_MS_CYCLES - 1;
   localparam [14:0] LAST = LAST_I[14:0];
   reg [14:0] cnt_r;
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cnt_r <= 15'h0000;
         tick <= 1'b0;
      end else if (restart || cnt_r == LAST) begin
         cnt_r <= 15'h0000;
         tick <= !restart;
      end else begin
         cnt_r <= cnt_r + 15'h0001;
         tick <= 1'b0;
      end
   end
endmodule // ouvfs_ms_tick

// [ouvfs_supervisor.v]
/*
 Output undervoltage fault supervisor with overvoltage warning flag.
 Assumes a decoded command port (write strobe, code, data), a telemetry sample with
 a one-cycle update strobe, and ramp, enable and turn-on-delay handshakes from the sequencer.
*/
`timescale 1ns/100ps
`include "ouvfs_defines.vh"
module ouvfs_supervisor (
   input wire clock, // Device clock, 25 MHz
   input wire rstn, // Power-on reset, active low
   input wire [15:0] setpoint_strap_pin, // Strapped setpoint code
   input wire cmd_wr, // Command write strobe
   input wire [7:0] cmd_code, // Command code
   input wire [15:0] cmd_wdata, // Command data
   input wire [7:0] rd_code, // Read command code
   output reg [15:0] rd_data, // Read data
   input wire sample_valid, // Telemetry update strobe
   input wire [15:0] vout_sample, // Output voltage code
   input wire output_good_flag, // Output good
   input wire ramping, // Output ramping
   input wire enable_cmd, // Enable pin and operation command on
   input wire bias_ok, // Bias power present
   input wire other_fault, // Another fault shut down
   input wire ton_done, // Turn-on delay expired
   output reg output_enable, // Output allowed to run
   output reg ton_start, // Start turn-on delay pulse
   output reg host_alert_line_n, // Alert, active low
   output reg [15:0] status_word, // Status word
   output reg [7:0] status_vout // Output-voltage status byte
);
   //--------------------------------------------------
   // States
   //--------------------------------------------------
   localparam [3:0] S_RUN = 4'b0001;
   localparam [3:0] S_WAIT = 4'b0010;
   localparam [3:0] S_TON = 4'b0100;
   localparam [3:0] S_LATCH = 4'b1000;
   localparam integer UNIT_I = `OUVFS_RETRY_UNIT_MS;
   localparam [5:0] UNIT = UNIT_I[5:0];

   //--------------------------------------------------
   // Registers and wires
   //--------------------------------------------------
   reg [15:0] ov_warn_r;
   reg [15:0] uv_warn_r;
   reg [15:0] uv_fault_r;
   reg [7:0] resp_r;
   reg [3:0] state_r;
   reg [8:0] ms_cnt_r;
   reg strap_done_r;
   wire tick;
   wire [31:0] warn_prod;
   wire [31:0] fault_prod;
   wire [31:0] ovw_prod;
   wire [8:0] delay_ms;
   wire uv_hit;
   wire ov_hit;
   wire clear;
   wire armed;

   //--------------------------------------------------
   // Strap defaults
   //--------------------------------------------------
   // Percent scaling of the strap; fractions are truncated
   assign warn_prod = ({16'h0000, setpoint_strap_pin} * {15'h0000, `OUVFS_WARN_NUM})
      / {15'h0000, `OUVFS_PCT_DIV};
   assign fault_prod = ({16'h0000, setpoint_strap_pin} * {15'h0000, `OUVFS_FAULT_NUM})
      / {15'h0000, `OUVFS_PCT_DIV};
   assign ovw_prod = ({16'h0000, setpoint_strap_pin} * {15'h0000, `OUVFS_OV_WARN_NUM})
      / {15'h0000, `OUVFS_PCT_DIV};

   //--------------------------------------------------
   // Retry delay and detection
   //--------------------------------------------------
   // Longest delay is 280 ms, which fits nine bits
   assign delay_ms = ({6'h00, resp_r[`OUVFS_RESP_DELAY]} + 9'h001) * {3'h0, UNIT};
   assign clear = cmd_wr && cmd_code == `OUVFS_CMD_CLEAR;
   // Retry states count as disabled, so no fault is raised there
   assign armed = state_r == S_RUN && output_good_flag && !ramping && enable_cmd;
   assign uv_hit = sample_valid && armed && vout_sample < uv_fault_r;
   // Overvoltage warning is not masked: it reports even while off
   assign ov_hit = sample_valid && vout_sample > ov_warn_r;

   //--------------------------------------------------
   // Retry time base
   //--------------------------------------------------
   // Restarted by each fault so the delay is timed from detection
   ouvfs_ms_tick u_tick (
      .clock(clock),
      .rstn(rstn),
      .restart(uv_hit),
      .tick(tick)
   );

   //--------------------------------------------------
   // Command registers
   //--------------------------------------------------
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ov_warn_r <= 16'h0000;
         uv_warn_r <= 16'h0000;
         uv_fault_r <= 16'h0000;
         resp_r <= `OUVFS_RESP_RESET;
         strap_done_r <= 1'b0;
      end else if (!strap_done_r) begin
         // First cycle after reset takes the strap defaults
         strap_done_r <= 1'b1;
         ov_warn_r <= ovw_prod[15:0];
         uv_warn_r <= warn_prod[15:0];
         uv_fault_r <= fault_prod[15:0];
      end else if (cmd_wr) begin
         case (cmd_code)
            `OUVFS_CMD_OV_WARN: begin
               if (cmd_wdata <= `OUVFS_MAX_CODE) ov_warn_r <= cmd_wdata;
            end
            `OUVFS_CMD_UV_WARN: begin
               if (cmd_wdata <= `OUVFS_MAX_CODE) uv_warn_r <= cmd_wdata;
            end
            `OUVFS_CMD_UV_FAULT: begin
               if (cmd_wdata <= `OUVFS_MAX_CODE) uv_fault_r <= cmd_wdata;
            end
            `OUVFS_CMD_UV_RESP: begin
               resp_r <= cmd_wdata[7:0];
            end
            default: begin
            end
         endcase
      end
   end

   //--------------------------------------------------
   // Read mux
   //--------------------------------------------------
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rd_data <= 16'h0000;
      end else begin
         // Registered, so data follows rd_code by one cycle
         case (rd_code)
            `OUVFS_CMD_OV_WARN: rd_data <= ov_warn_r;
            `OUVFS_CMD_UV_WARN: rd_data <= uv_warn_r;
            `OUVFS_CMD_UV_FAULT: rd_data <= uv_fault_r;
            `OUVFS_CMD_UV_RESP: rd_data <= {8'h00, resp_r};
            default: rd_data <= 16'h0000;
         endcase
      end
   end

   //--------------------------------------------------
   // Status and alert, set wins over clear
   //--------------------------------------------------
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         status_word <= 16'h0000;
         status_vout <= 8'h00;
         host_alert_line_n <= 1'b1;
      end else if (uv_hit || ov_hit) begin
         // A clear-faults in the same cycle is ignored
         status_word[`OUVFS_SW_VOUT_BIT] <= 1'b1;
         if (uv_hit) status_vout[`OUVFS_SV_UV_FAULT_BIT] <= 1'b1;
         if (ov_hit) status_vout[`OUVFS_SV_OV_WARN_BIT] <= 1'b1;
         host_alert_line_n <= 1'b0;
      end else if (clear) begin
         status_word <= 16'h0000;
         status_vout <= 8'h00;
         host_alert_line_n <= 1'b1;
      end
   end

   //--------------------------------------------------
   // Fault response sequencer
   //--------------------------------------------------
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_r <= S_RUN;
         ms_cnt_r <= 9'h000;
         output_enable <= 1'b1;
         ton_start <= 1'b0;
      end else begin
         ton_start <= 1'b0;
         case (state_r)
            S_RUN: begin
               output_enable <= 1'b1;
               // Other response patterns only report; the output stays on
               if (uv_hit && resp_r[`OUVFS_RESP_MODE] == `OUVFS_RESP_RETRY_MODE) begin
                  output_enable <= 1'b0;
                  ms_cnt_r <= 9'h000;
                  if (resp_r[`OUVFS_RESP_RETRY] == 3'h0) state_r <= S_LATCH;
                  else state_r <= S_WAIT;
               end
            end
            S_WAIT: begin
               // Disable, bias loss or another fault ends the retries
               if (!enable_cmd || !bias_ok || other_fault) begin
                  state_r <= S_LATCH;
               end else if (tick) begin
                  // ms_cnt_r counts whole milliseconds since the fault
                  if (ms_cnt_r + 9'h001 >= delay_ms) begin
                     state_r <= S_TON;
                     ton_start <= 1'b1;
                  end
                  ms_cnt_r <= ms_cnt_r + 9'h001;
               end
            end
            S_TON: begin
               // Turn-on delay is honoured before the output runs again
               if (!enable_cmd || !bias_ok || other_fault) begin
                  state_r <= S_LATCH;
               end else if (ton_done) begin
                  output_enable <= 1'b1;
                  state_r <= S_RUN;
               end
            end
            S_LATCH: begin
               // Only clear-faults leaves the latched-off state
               output_enable <= 1'b0;
               if (clear) state_r <= S_RUN;
            end
            default: state_r <= S_RUN;
         endcase
      end
   end
endmodule // ouvfs_supervisor

// [ouvfs_sup_asserts.sv]
/* Checker for ouvfs_supervisor ports.
   Assumes thresholds above zero and the 25 MHz clock. */
`timescale 1ns/100ps
`include "ouvfs_defines.vh"
module ouvfs_sup_asserts (
   input wire clock, // Clock
   input wire rstn, // Reset
   input wire cmd_wr, // Write
   input wire [7:0] cmd_code, // Code
   input wire sample_valid, // Strobe
   input wire [15:0] vout_sample, // Sample
   input wire output_good_flag, // Good
   input wire ramping, // Ramp
   input wire enable_cmd, // On
   input wire output_enable, // Run
   input wire ton_start, // Start
   input wire host_alert_line_n, // Alert
   input wire [15:0] status_word, // Word
   input wire [7:0] status_vout // Byte
);
   localparam int RETRY_MIN = 35 * 25000;
   // Cycles with the output off, saturating past the longest retry delay
   reg [22:0] off_r;
   wire clr = cmd_wr && cmd_code == `OUVFS_CMD_CLEAR;
   wire arm = output_good_flag && !ramping && enable_cmd;
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   always @(posedge clock or negedge rstn) begin
      if (!rstn)
         off_r <= 23'h0;
      else
         off_r <= output_enable ? 23'h0 : (&off_r ? off_r : off_r + 23'h1);
   end
   sequence s_low; sample_valid && vout_sample == 16'h0 && arm && output_enable; endsequence
   sequence s_flag; status_vout[4] && status_word[15] && !host_alert_line_n; endsequence
   property p_uv_set; s_low |=> s_flag; endproperty
   a_uv_set: assert property (p_uv_set) else $error("uv flags missing");
   property p_mask; sample_valid && !arm && !status_vout[4] |=> !status_vout[4]; endproperty
   a_mask: assert property (p_mask) else $error("masked uv flagged");
   property p_alert; !host_alert_line_n && !clr |=> !host_alert_line_n; endproperty
   a_alert: assert property (p_alert) else $error("alert dropped");
   property p_bit; status_vout[4] && !clr |=> $stable(status_vout[4]); endproperty
   a_bit: assert property (p_bit) else $error("uv bit dropped");
   property p_clear; clr && !sample_valid |=> status_vout == 8'h0 && host_alert_line_n; endproperty
   a_clear: assert property (p_clear) else $error("clear ignored");
   property p_ov; sample_valid && vout_sample == 16'hffff |=> status_vout[6] && status_word[15]; endproperty
   a_ov: assert property (p_ov) else $error("ov warn missing");
   property p_gap; ton_start |-> off_r >= RETRY_MIN; endproperty
   a_gap: assert property (p_gap) else $error("retry too early");
   property p_ton; ton_start |-> !output_enable ##1 !ton_start; endproperty
   a_ton: assert property (p_ton) else $error("start while on");
endmodule // ouvfs_sup_asserts
bind ouvfs_supervisor ouvfs_sup_asserts u_chk (.clock(clock), .rstn(rstn), .cmd_wr(cmd_wr),
   .cmd_code(cmd_code), .sample_valid(sample_valid), .vout_sample(vout_sample),
   .output_good_flag(output_good_flag), .ramping(ramping), .enable_cmd(enable_cmd),
   .output_enable(output_enable), .ton_start(ton_start), .host_alert_line_n(host_alert_line_n),
   .status_word(status_word), .status_vout(status_vout));

// [ouvfs_seq_model.sv]
/* Sequencer model answering the turn-on delay.
   Assumes ton_start is a one-cycle pulse. */
`timescale 1ns/100ps
module ouvfs_seq_model #(parameter DLY = 4) (
   input wire clock, // Clock
   input wire rstn, // Reset
   input wire ton_start, // Start
   output reg ton_done // Expired
);
   integer cnt_r;
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cnt_r <= 0;
         ton_done <= 1'b0;
      end else begin
         ton_done <= cnt_r == 1;
         cnt_r <= ton_start ? DLY : (cnt_r != 0 ? cnt_r - 1 : 0);
      end
   end
endmodule // ouvfs_seq_model

// [tb_top.sv]
/* Bench for ouvfs_supervisor.
   Assumes strap 1.0 V, then 2.0 V after a mid-run reset; retry delays outlast the run. */
`timescale 1ns/100ps
`define TB_CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin failures++; \
   $display("wrong value %s exp %h got %h", n, e, s); end end
module tb_top;
   logic clock = 1'b0, rstn = 1'b0, cmd_wr = 1'b0, sample_valid = 1'b0;
   logic output_good_flag = 1'b1, ramping = 1'b0, enable_cmd = 1'b1;
   logic bias_ok = 1'b1, other_fault = 1'b0;
   logic [15:0] strap = 16'h2000;
   logic [7:0] cmd_code = 8'h0, rd_code = 8'h0, status_vout;
   logic [15:0] cmd_wdata = 16'h0, vout_sample = 16'h2000, d, rd_data, status_word;
   logic output_enable, ton_start, ton_done, host_alert_line_n;
   logic [7:0] ca [4] = '{8'h43, 8'h44, 8'h42, 8'h45};
   logic [15:0] ea [4] = '{16'h1c28, 16'h1b33, 16'h228f, 16'h0080};
   logic [15:0] eb [4] = '{16'h3851, 16'h3666, 16'h451e, 16'h0080};
   int failures = 0, samples_checked = 0;
   ouvfs_supervisor dut (.clock(clock), .rstn(rstn), .setpoint_strap_pin(strap),
      .cmd_wr(cmd_wr), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rd_code(rd_code),
      .rd_data(rd_data), .sample_valid(sample_valid), .vout_sample(vout_sample),
      .output_good_flag(output_good_flag), .ramping(ramping), .enable_cmd(enable_cmd),
      .bias_ok(bias_ok), .other_fault(other_fault), .ton_done(ton_done),
      .output_enable(output_enable),
      .ton_start(ton_start), .host_alert_line_n(host_alert_line_n),
      .status_word(status_word), .status_vout(status_vout));
   ouvfs_seq_model seq (.clock(clock), .rstn(rstn), .ton_start(ton_start), .ton_done(ton_done));
   initial forever #20 clock = ~clock;
   task automatic wr(input logic [7:0] c, input logic [15:0] v);
      @(posedge clock);
      cmd_wr <= 1'b1;
      cmd_code <= c;
      cmd_wdata <= v;
      @(posedge clock);
      cmd_wr <= 1'b0;
      repeat (2) @(posedge clock);
      #1;
   endtask
   task automatic rd(input logic [7:0] c);
      @(posedge clock);
      rd_code <= c;
      repeat (2) @(posedge clock);
      #1 d = rd_data;
   endtask
   task automatic samp(input logic [15:0] v);
      @(posedge clock);
      sample_valid <= 1'b1;
      vout_sample <= v;
      @(posedge clock);
      sample_valid <= 1'b0;
      @(posedge clock);
      #1;
   endtask
   task automatic conclude;
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (4000) @(posedge clock);
      failures++;
      conclude;
   end
   initial begin
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      repeat (2) @(posedge clock);
      foreach (ca[i]) begin
         rd(ca[i]);
         `TB_CHK("reset level", ea[i], d)
      end
      wr(8'h43, 16'hb000);
      rd(8'h43);
      `TB_CHK("warn top", 16'hb000, d)
      wr(8'h43, 16'hb001);
      rd(8'h43);
      `TB_CHK("warn kept", 16'hb000, d)
      wr(8'h43, 16'h1c28);
      wr(8'h45, 16'h0000);
      rd(8'h45);
      `TB_CHK("response", 16'h0000, d)
      for (int i = 0; i < 3; i++) begin
         @(posedge clock);
         output_good_flag <= i != 0;
         ramping <= i == 1;
         samp(i == 2 ? 16'h1b33 : 16'h0000);
         `TB_CHK("masked", 8'h00, status_vout)
      end
      samp(16'h1b32);
      `TB_CHK("uv byte", 8'h10, status_vout)
      `TB_CHK("summary", 1'b1, status_word[15])
      `TB_CHK("alert", 1'b0, host_alert_line_n)
      `TB_CHK("kept on", 1'b1, output_enable)
      wr(8'h03, 16'h0);
      `TB_CHK("cleared", 8'h00, status_vout)
      `TB_CHK("alert off", 1'b1, host_alert_line_n)
      samp(16'hffff);
      `TB_CHK("ov byte", 8'h40, status_vout)
      wr(8'h03, 16'h0);
      wr(8'h45, 16'h0080);
      samp(16'h0000);
      `TB_CHK("off", 1'b0, output_enable)
      repeat (300) @(posedge clock);
      `TB_CHK("still off", 1'b0, output_enable)
      `TB_CHK("held", 8'h10, status_vout)
      wr(8'h03, 16'h0);
      @(posedge clock);
      enable_cmd <= 1'b0;
      samp(16'h0000);
      `TB_CHK("disabled", 8'h00, status_vout)
      @(posedge clock);
      enable_cmd <= 1'b1;
      wr(8'h45, 16'h0088);
      for (int i = 0; i < 3; i++) begin
         samp(16'h0000);
         `TB_CHK("retry off", 1'b0, output_enable)
         @(posedge clock);
         enable_cmd <= i != 0;
         bias_ok <= i != 1;
         other_fault <= i == 2;
         @(posedge clock);
         enable_cmd <= 1'b1;
         bias_ok <= 1'b1;
         other_fault <= 1'b0;
         wr(8'h03, 16'h0);
         `TB_CHK("retry ended", 1'b1, output_enable)
      end
      @(posedge clock);
      rstn <= 1'b0;
      strap <= 16'h4000;
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      repeat (2) @(posedge clock);
      foreach (ca[i]) begin
         rd(ca[i]);
         `TB_CHK("reset again", eb[i], d)
      end
      conclude;
   end
endmodule // tb_top
